// *** rtl/mbsl_pkg.sv ***
package mbsl_pkg;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int HRST_QUAL_MS   = 400;
    localparam int HRST_QUAL_CYC  = (HRST_QUAL_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEM_STROBE_NS  = 64;
    localparam int MEM_STROBE_CYC = (MEM_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NVM_SK_HALF_NS = 1000;
    localparam int NVM_SK_HALF_CYC = (NVM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [2:0] NVM_READ_CMD  = 3'h6;
    localparam logic [4:0] NVM_CMD_BITS  = 5'h09;
    localparam logic [4:0] NVM_DATA_LO   = 5'h0A;
    localparam logic [4:0] NVM_GAP_SLOT  = 5'h1A;
    localparam logic [2:0] NVM_LAST_WORD = 3'h5;
    localparam logic [2:0] NVM_PROM_WORD = 3'h2;
    localparam logic [7:0] NVM_PIN_OE    = 8'h06;
    localparam int         NVM_DO_BIT    = 0;
    localparam int         NVM_DI_BIT    = 1;
    localparam int         NVM_SK_BIT    = 2;

    localparam int         ADDR_A13_IDX  = 12;
    localparam int         ADDR_A15_IDX  = 14;
    localparam int         PROM_BYTES    = 8;

    typedef enum logic [2:0] {
        ST_HRST = 3'b000,
        ST_NVM  = 3'b001,
        ST_IDLE = 3'b010,
        ST_RD   = 3'b011,
        ST_WR   = 3'b100
    } mbsl_state_t;
endpackage : mbsl_pkg

// *** rtl/mbsl_top.sv ***
// How it works
// - low data byte is bus outside reset and serial load
// - qualified reset fall captures A, B, C straps
// - undriven A/B strap pins read zero
// - qualified reset release starts serial memory read
// - bit0 serial out, bit1 in, bit2 clock
// - loaded words fill config and station storage
// - high data byte is upper bus half
// - low address pins drive A1-A8 outside reset
// - high address pins drive A9-A15
// - byte RAM: A0 on A13 or A15
// - read strobe low, capture returned data
// - write strobe low while driving data
// - boot PROM select low on PROM access
// - separate low/high byte RAM selects
// - serial memory select high during load, low in the gap slot after each word
// - load strap low skips serial load
module mbsl_top #(
    parameter logic [25:0] QUAL_CYC = 26'(mbsl_pkg::HRST_QUAL_CYC)
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        host_reset,
    input  wire logic        load_from_nvm_strap,
    input  wire logic        wide_slot_strap,
    input  wire logic [7:0]  mem_data_low_byte_in,
    output logic      [7:0]  mem_data_low_byte_out,
    output logic      [7:0]  mem_data_low_byte_oe,
    input  wire logic [7:0]  mem_data_high_byte_in,
    output logic      [7:0]  mem_data_high_byte_out,
    output logic      [7:0]  mem_data_high_byte_oe,
    input  wire logic [7:0]  mem_addr_low_in,
    output logic      [7:0]  mem_addr_low_out,
    output logic      [7:0]  mem_addr_low_oe,
    output logic      [6:0]  mem_addr_high,
    output logic             mem_read_strobe_n,
    output logic             mem_write_strobe_n,
    output logic             bootrom_select_n,
    output logic             ram_low_select_n,
    output logic             ram_high_select_n,
    output logic             nvm_select,
    input  wire logic        byte_wide,
    input  wire logic        compat_mode,
    input  wire logic        acc_req,
    input  wire logic        acc_write,
    input  wire logic        acc_prom,
    input  wire logic [15:0] acc_addr,
    input  wire logic [15:0] acc_wdata,
    output logic             acc_ready,
    output logic             acc_done,
    output logic      [15:0] acc_rdata,
    output logic      [7:0]  cfg_a,
    output logic      [7:0]  cfg_b,
    output logic      [7:0]  cfg_c,
    output logic             wide_slot,
    output logic             nvm_busy,
    input  wire logic [2:0]  prom_idx,
    output logic      [7:0]  prom_byte
);
    mbsl_pkg::mbsl_state_t st_r, st_nxt;
    logic        hrst_q_r, hrst_q_nxt;
    logic [25:0] qcnt_r, qcnt_nxt;
    logic [7:0]  cfg_a_r, cfg_a_nxt, cfg_b_r, cfg_b_nxt, cfg_c_r, cfg_c_nxt;
    logic        wide_r, wide_nxt;
    logic [7:0]  prom_r [mbsl_pkg::PROM_BYTES];
    logic [7:0]  prom_nxt [mbsl_pkg::PROM_BYTES];
    logic [14:0] ap_r, ap_nxt;
    logic [15:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [3:0]  scnt_r, scnt_nxt;
    logic        rdn_r, rdn_nxt, wrn_r, wrn_nxt, done_r, done_nxt;
    logic        bpn_r, bpn_nxt, rlo_r, rlo_nxt, rhi_r, rhi_nxt, bw_r, bw_nxt;
    logic [6:0]  half_r, half_nxt;
    logic        sk_r, sk_nxt, di_r, di_nxt;
    logic [4:0]  slot_r, slot_nxt;
    logic [2:0]  word_r, word_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic        hrst_fall, qual_ok;

    function automatic logic cmd_bit(input logic [4:0] slot, input logic [2:0] word);
        logic [8:0] cmd;
        cmd = {mbsl_pkg::NVM_READ_CMD, 3'h0, word};
        if (slot < mbsl_pkg::NVM_CMD_BITS) begin
            cmd_bit = cmd[4'(mbsl_pkg::NVM_CMD_BITS - 5'h01 - slot)];
        end else begin
            cmd_bit = 1'b0;
        end
    endfunction : cmd_bit

    assign hrst_fall = hrst_q_r & ~host_reset;
    assign qual_ok   = qcnt_r >= QUAL_CYC;

    always_comb begin
        st_nxt     = st_r;
        hrst_q_nxt = host_reset;
        qcnt_nxt   = host_reset ? ((qcnt_r >= QUAL_CYC) ? qcnt_r : qcnt_r + 26'h0000001) : 26'h0000000;
        cfg_a_nxt  = cfg_a_r;
        cfg_b_nxt  = cfg_b_r;
        cfg_c_nxt  = cfg_c_r;
        wide_nxt   = wide_r;
        prom_nxt   = prom_r;
        ap_nxt     = ap_r;
        wd_nxt     = wd_r;
        rd_nxt     = rd_r;
        scnt_nxt   = scnt_r;
        rdn_nxt    = rdn_r;
        wrn_nxt    = wrn_r;
        done_nxt   = 1'b0;
        bpn_nxt    = bpn_r;
        rlo_nxt    = rlo_r;
        rhi_nxt    = rhi_r;
        bw_nxt     = bw_r;
        half_nxt   = half_r;
        sk_nxt     = sk_r;
        di_nxt     = di_r;
        slot_nxt   = slot_r;
        word_nxt   = word_r;
        sh_nxt     = sh_r;
        if (host_reset) begin
            st_nxt  = mbsl_pkg::ST_HRST;
            rdn_nxt = 1'b1;
            wrn_nxt = 1'b1;
            bpn_nxt = 1'b1;
            rlo_nxt = 1'b1;
            rhi_nxt = 1'b1;
            sk_nxt  = 1'b0;
            di_nxt  = 1'b0;
        end else begin
            case (st_r)
                mbsl_pkg::ST_HRST: begin
                    st_nxt = mbsl_pkg::ST_IDLE;
                    if (hrst_fall && qual_ok) begin
                        // undriven A/B pins are pulled low so capture reads zero
                        cfg_a_nxt = mem_data_low_byte_in;
                        cfg_b_nxt = mem_data_high_byte_in;
                        cfg_c_nxt = mem_addr_low_in;
                        wide_nxt  = wide_slot_strap;
                        if (load_from_nvm_strap) begin
                            st_nxt = mbsl_pkg::ST_NVM;
                        end
                        half_nxt = 7'h00;
                        slot_nxt = 5'h00;
                        word_nxt = 3'h0;
                        sk_nxt   = 1'b0;
                        di_nxt   = cmd_bit(5'h00, 3'h0);
                    end
                end
                mbsl_pkg::ST_NVM: begin
                    if (half_r == 7'(mbsl_pkg::NVM_SK_HALF_CYC - 1)) begin
                        half_nxt = 7'h00;
                        sk_nxt   = ~sk_r;
                        if (sk_r) begin
                            if (slot_r >= mbsl_pkg::NVM_DATA_LO && slot_r < mbsl_pkg::NVM_GAP_SLOT) begin
                                sh_nxt = {sh_r[14:0], mem_data_low_byte_in[mbsl_pkg::NVM_DO_BIT]};
                            end
                            slot_nxt = slot_r + 5'h01;
                            di_nxt   = cmd_bit(slot_r + 5'h01, word_r);
                            if (slot_r == mbsl_pkg::NVM_GAP_SLOT) begin
                                slot_nxt = 5'h00;
                                word_nxt = word_r + 3'h1;
                                di_nxt   = cmd_bit(5'h00, word_r + 3'h1);
                                if (word_r == 3'h0) begin
                                    cfg_a_nxt = sh_r[7:0];
                                    cfg_b_nxt = sh_r[15:8];
                                end else if (word_r == 3'h1) begin
                                    cfg_c_nxt = sh_r[7:0];
                                end else begin
                                    prom_nxt[{word_r[1:0], 1'b0}] = sh_r[7:0];
                                    prom_nxt[{word_r[1:0], 1'b1}] = sh_r[15:8];
                                end
                                if (word_r == mbsl_pkg::NVM_LAST_WORD) begin
                                    st_nxt = mbsl_pkg::ST_IDLE;
                                    di_nxt = 1'b0;
                                end
                            end
                        end
                    end else begin
                        half_nxt = half_r + 7'h01;
                    end
                end
                mbsl_pkg::ST_IDLE: begin
                    if (acc_req) begin
                        ap_nxt = acc_addr[15:1];
                        bw_nxt = byte_wide;
                        if (byte_wide) begin
                            if (compat_mode) begin
                                ap_nxt[mbsl_pkg::ADDR_A13_IDX] = acc_addr[0];
                            end else begin
                                ap_nxt[mbsl_pkg::ADDR_A15_IDX] = acc_addr[0];
                            end
                        end
                        wd_nxt   = acc_wdata;
                        scnt_nxt = 4'h0;
                        bpn_nxt  = ~acc_prom;
                        rlo_nxt  = acc_prom;
                        rhi_nxt  = acc_prom | byte_wide;
                        if (acc_write) begin
                            st_nxt  = mbsl_pkg::ST_WR;
                            wrn_nxt = 1'b0;
                        end else begin
                            st_nxt  = mbsl_pkg::ST_RD;
                            rdn_nxt = 1'b0;
                        end
                    end
                end
                mbsl_pkg::ST_RD, mbsl_pkg::ST_WR: begin
                    scnt_nxt = scnt_r + 4'h1;
                    if (scnt_r == 4'(mbsl_pkg::MEM_STROBE_CYC - 1)) begin
                        if (st_r == mbsl_pkg::ST_RD) begin
                            rd_nxt = {mem_data_high_byte_in, mem_data_low_byte_in};
                        end
                        rdn_nxt  = 1'b1;
                        wrn_nxt  = 1'b1;
                        bpn_nxt  = 1'b1;
                        rlo_nxt  = 1'b1;
                        rhi_nxt  = 1'b1;
                        done_nxt = 1'b1;
                        st_nxt   = mbsl_pkg::ST_IDLE;
                    end
                end
                default: st_nxt = mbsl_pkg::ST_HRST;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r     <= mbsl_pkg::ST_HRST;
            hrst_q_r <= 1'b0;
            qcnt_r   <= 26'h0000000;
            cfg_a_r  <= 8'h00;
            cfg_b_r  <= 8'h00;
            cfg_c_r  <= 8'h00;
            wide_r   <= 1'b0;
            for (int i = 0; i < mbsl_pkg::PROM_BYTES; i++) begin
                prom_r[i] <= 8'h00;
            end
            ap_r     <= 15'h0000;
            wd_r     <= 16'h0000;
            rd_r     <= 16'h0000;
            scnt_r   <= 4'h0;
            rdn_r    <= 1'b1;
            wrn_r    <= 1'b1;
            done_r   <= 1'b0;
            bpn_r    <= 1'b1;
            rlo_r    <= 1'b1;
            rhi_r    <= 1'b1;
            bw_r     <= 1'b0;
            half_r   <= 7'h00;
            sk_r     <= 1'b0;
            di_r     <= 1'b0;
            slot_r   <= 5'h00;
            word_r   <= 3'h0;
            sh_r     <= 16'h0000;
        end else begin
            st_r     <= st_nxt;
            hrst_q_r <= hrst_q_nxt;
            qcnt_r   <= qcnt_nxt;
            cfg_a_r  <= cfg_a_nxt;
            cfg_b_r  <= cfg_b_nxt;
            cfg_c_r  <= cfg_c_nxt;
            wide_r   <= wide_nxt;
            prom_r   <= prom_nxt;
            ap_r     <= ap_nxt;
            wd_r     <= wd_nxt;
            rd_r     <= rd_nxt;
            scnt_r   <= scnt_nxt;
            rdn_r    <= rdn_nxt;
            wrn_r    <= wrn_nxt;
            done_r   <= done_nxt;
            bpn_r    <= bpn_nxt;
            rlo_r    <= rlo_nxt;
            rhi_r    <= rhi_nxt;
            bw_r     <= bw_nxt;
            half_r   <= half_nxt;
            sk_r     <= sk_nxt;
            di_r     <= di_nxt;
            slot_r   <= slot_nxt;
            word_r   <= word_nxt;
            sh_r     <= sh_nxt;
        end
    end

    logic nvm_on;
    assign nvm_on = st_r == mbsl_pkg::ST_NVM;
    always_comb begin
        mem_data_low_byte_out = wd_r[7:0];
        mem_data_low_byte_oe  = (st_r == mbsl_pkg::ST_WR) ? 8'hFF : 8'h00;
        if (nvm_on) begin
            mem_data_low_byte_out                         = 8'h00;
            mem_data_low_byte_out[mbsl_pkg::NVM_DI_BIT]   = di_r;
            mem_data_low_byte_out[mbsl_pkg::NVM_SK_BIT]   = sk_r;
            mem_data_low_byte_oe                          = mbsl_pkg::NVM_PIN_OE;
        end
    end
    assign mem_data_high_byte_out = wd_r[15:8];
    assign mem_data_high_byte_oe  = (st_r == mbsl_pkg::ST_WR && !bw_r) ? 8'hFF : 8'h00;
    assign mem_addr_low_out       = ap_r[7:0];
    assign mem_addr_low_oe        = (st_r == mbsl_pkg::ST_HRST) ? 8'h00 : 8'hFF;
    assign mem_addr_high          = ap_r[14:8];
    assign mem_read_strobe_n      = rdn_r;
    assign mem_write_strobe_n     = wrn_r;
    assign bootrom_select_n       = bpn_r;
    assign ram_low_select_n       = rlo_r;
    assign ram_high_select_n      = rhi_r;
    assign nvm_select             = nvm_on && slot_r != mbsl_pkg::NVM_GAP_SLOT;
    assign acc_ready              = st_r == mbsl_pkg::ST_IDLE && !host_reset;
    assign acc_done               = done_r;
    assign acc_rdata              = rd_r;
    assign cfg_a                  = cfg_a_r;
    assign cfg_b                  = cfg_b_r;
    assign cfg_c                  = cfg_c_r;
    assign wide_slot              = wide_r;
    assign nvm_busy               = nvm_on;
    assign prom_byte              = prom_r[prom_idx];

    property p_strobe_excl;
        @(posedge clock) disable iff (rst) !(!mem_read_strobe_n && !mem_write_strobe_n);
    endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
    property p_capture;
        @(posedge clock) disable iff (rst) (hrst_fall && qual_ok) |=> cfg_a == $past(mem_data_low_byte_in)
            && cfg_c == $past(mem_addr_low_in);
    endproperty
    a_capture: assert property (p_capture) else $error("straps not captured on reset fall");
    property p_nvm_start;
        @(posedge clock) disable iff (rst) (hrst_fall && qual_ok && load_from_nvm_strap) |=> nvm_busy ##1 nvm_select;
    endproperty
    a_nvm_start: assert property (p_nvm_start) else $error("serial load not started");
    property p_skip;
        @(posedge clock) disable iff (rst) (hrst_fall && !load_from_nvm_strap) |=> !nvm_busy && acc_ready;
    endproperty
    a_skip: assert property (p_skip) else $error("serial load not skipped");
    property p_nvm_pins;
        @(posedge clock) disable iff (rst) nvm_busy |-> mem_data_low_byte_oe == 8'h06
            && mem_data_low_byte_out[2] == sk_r && mem_data_high_byte_oe == 8'h00;
    endproperty
    a_nvm_pins: assert property (p_nvm_pins) else $error("serial pins wrong");
    property p_read_len;
        @(posedge clock) disable iff (rst) $fell(mem_read_strobe_n) |-> !mem_read_strobe_n [*8] ##1 mem_read_strobe_n
            ##0 acc_done;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read strobe length wrong");
    property p_write_drive;
        @(posedge clock) disable iff (rst) !mem_write_strobe_n |-> mem_data_low_byte_oe == 8'hFF
            && mem_data_low_byte_out == wd_r[7:0];
    endproperty
    a_write_drive: assert property (p_write_drive) else $error("write data not driven");
    property p_a0_pos;
        @(posedge clock) disable iff (rst) (acc_req && acc_ready && byte_wide && compat_mode) |=>
            mem_addr_high[4] == $past(acc_addr[0]);
    endproperty
    a_a0_pos: assert property (p_a0_pos) else $error("byte address bit misplaced");
    property p_prom_sel;
        @(posedge clock) disable iff (rst) (acc_req && acc_ready && acc_prom) |=>
            !bootrom_select_n && ram_low_select_n;
    endproperty
    a_prom_sel: assert property (p_prom_sel) else $error("boot PROM select missing");
    property p_addr_float;
        @(posedge clock) disable iff (rst) $rose(host_reset) |=> mem_addr_low_oe == 8'h00 && mem_read_strobe_n;
    endproperty
    a_addr_float: assert property (p_addr_float) else $error("address pins driven in reset");
endmodule : mbsl_top

// *** test/mbsl_mem_model.sv ***
module mbsl_mem_model (
    input  wire logic       clock,
    input  wire logic [7:0] mem_data_low_byte_out,
    input  wire logic [7:0] mem_data_high_byte_out,
    input  wire logic [7:0] mem_addr_low_out,
    input  wire logic [6:0] mem_addr_high,
    input  wire logic       mem_read_strobe_n,
    input  wire logic       mem_write_strobe_n,
    input  wire logic       bootrom_select_n,
    input  wire logic       ram_low_select_n,
    input  wire logic       ram_high_select_n,
    input  wire logic       nvm_select,
    output logic      [7:0] low_drive,
    output logic      [7:0] low_drive_en,
    output logic      [7:0] high_drive,
    output logic      [7:0] high_drive_en
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  ram_lo [0:32767];
    logic [7:0]  ram_hi [0:32767];
    logic [14:0] pin_addr;
    logic [15:0] w_cur;
    logic [5:0]  slot = 6'h00;
    logic [5:0]  word_addr = 6'h00;
    logic [2:0]  cmd = 3'h0;
    logic        sk_q = 1'b0;
    logic        do_r = 1'b0;

    function automatic logic [15:0] nvm_word(input logic [5:0] w);
        return {8'h3C + {2'h0, w} * 8'h11, 8'hA1 ^ ({2'h0, w} * 8'h25)};
    endfunction : nvm_word

    assign pin_addr = {mem_addr_high, mem_addr_low_out};
    assign w_cur    = nvm_word(word_addr);

    // ram write lanes plus serial memory shifter, on clock; shifter steps on rising edges of its clock pin
    always @(posedge clock) begin
        if (!mem_write_strobe_n && !ram_low_select_n) ram_lo[pin_addr] <= mem_data_low_byte_out;
        if (!mem_write_strobe_n && !ram_high_select_n) ram_hi[pin_addr] <= mem_data_high_byte_out;
        sk_q <= mem_data_low_byte_out[2];
        if (!nvm_select) begin
            slot <= 6'h00;
        end else if (mem_data_low_byte_out[2] && !sk_q) begin
            slot <= slot + 6'h01;
            if (slot < 6'h03) cmd <= {cmd[1:0], mem_data_low_byte_out[1]};
            if (slot >= 6'h03 && slot <= 6'h08) word_addr <= {word_addr[4:0], mem_data_low_byte_out[1]};
            if (slot >= 6'h0A && slot <= 6'h19) do_r <= (cmd == 3'h6) ? w_cur[25 - slot] : 1'b0;
        end
    end

    always_comb begin
        low_drive     = 8'h00;
        low_drive_en  = 8'h00;
        high_drive    = 8'h00;
        high_drive_en = 8'h00;
        if (!mem_read_strobe_n && !bootrom_select_n) begin
            low_drive    = pin_addr[7:0] ^ 8'h5A;
            low_drive_en = 8'hFF;
        end else if (!mem_read_strobe_n) begin
            if (!ram_low_select_n) begin
                low_drive    = ram_lo[pin_addr];
                low_drive_en = 8'hFF;
            end
            if (!ram_high_select_n) begin
                high_drive    = ram_hi[pin_addr];
                high_drive_en = 8'hFF;
            end
        end
        if (nvm_select) begin
            low_drive[0]    = do_r;
            low_drive_en[0] = 1'b1;
        end
    end
endmodule : mbsl_mem_model

// *** test/memory_bus_strap_loader_tb.sv ***
module memory_bus_strap_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 0, rst = 1, host_reset = 0, load_s = 0, ws_s = 0, ab_en = 0;
    logic [7:0]  sa = 0, sb = 0, sc = 0;
    logic        byte_wide = 0, compat_mode = 0, acc_req = 0, acc_write = 0, acc_prom = 0;
    logic [15:0] acc_addr = 0, acc_wdata = 0;
    logic [2:0]  prom_idx = 0;
    logic [7:0]  dlo_in, dlo_o, dlo_oe, dhi_in, dhi_o, dhi_oe, alo_in, alo_o, alo_oe;
    logic [7:0]  ca, cb, cc, pbyte, mlo, mlo_en, mhi, mhi_en;
    logic [6:0]  ahi;
    logic        rd_n, wr_n, bp_n, rl_n, rh_n, nsel, ready, done, wslot, busy;
    logic [15:0] rdata;
    logic [15:0] shadow [int];
    int          errors = 0;
    int          total_checks = 0;

    always #4 clock = ~clock;

    // pull-downs on data pins, A/B straps driven only while the board holds them, C strap always driven
    assign dlo_in = (dlo_oe & dlo_o) | (~dlo_oe & (ab_en ? sa : (mlo & mlo_en)));
    assign dhi_in = (dhi_oe & dhi_o) | (~dhi_oe & (ab_en ? sb : (mhi & mhi_en)));
    assign alo_in = (alo_oe & alo_o) | (~alo_oe & sc);

    mbsl_top #(.QUAL_CYC(26'd20)) dut (
        .clock(clock), .rst(rst), .host_reset(host_reset), .load_from_nvm_strap(load_s),
        .wide_slot_strap(ws_s), .mem_data_low_byte_in(dlo_in), .mem_data_low_byte_out(dlo_o),
        .mem_data_low_byte_oe(dlo_oe), .mem_data_high_byte_in(dhi_in), .mem_data_high_byte_out(dhi_o),
        .mem_data_high_byte_oe(dhi_oe), .mem_addr_low_in(alo_in), .mem_addr_low_out(alo_o),
        .mem_addr_low_oe(alo_oe), .mem_addr_high(ahi), .mem_read_strobe_n(rd_n), .mem_write_strobe_n(wr_n),
        .bootrom_select_n(bp_n), .ram_low_select_n(rl_n), .ram_high_select_n(rh_n), .nvm_select(nsel),
        .byte_wide(byte_wide), .compat_mode(compat_mode), .acc_req(acc_req), .acc_write(acc_write),
        .acc_prom(acc_prom), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ready(ready),
        .acc_done(done), .acc_rdata(rdata), .cfg_a(ca), .cfg_b(cb), .cfg_c(cc), .wide_slot(wslot),
        .nvm_busy(busy), .prom_idx(prom_idx), .prom_byte(pbyte));

    mbsl_mem_model partner (
        .clock(clock), .mem_data_low_byte_out(dlo_o), .mem_data_high_byte_out(dhi_o),
        .mem_addr_low_out(alo_o), .mem_addr_high(ahi), .mem_read_strobe_n(rd_n),
        .mem_write_strobe_n(wr_n), .bootrom_select_n(bp_n), .ram_low_select_n(rl_n),
        .ram_high_select_n(rh_n), .nvm_select(nsel), .low_drive(mlo), .low_drive_en(mlo_en),
        .high_drive(mhi), .high_drive_en(mhi_en));

    function automatic logic [15:0] nvm_word(input int w);
        return {8'h3C + 8'(w) * 8'h11, 8'hA1 ^ (8'(w) * 8'h25)};
    endfunction : nvm_word

    function automatic logic [14:0] exp_pins(input logic [15:0] a, input logic bw, input logic cm);
        logic [14:0] v;
        v = a[15:1];
        if (bw) v[cm ? mbsl_pkg::ADDR_A13_IDX : mbsl_pkg::ADDR_A15_IDX] = a[0];
        return v;
    endfunction : exp_pins

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic hreset(input int n, input logic ld, input logic drv);
        sa = 8'($urandom);
        sb = 8'($urandom);
        sc = 8'($urandom);
        ws_s = 1'($urandom);
        load_s = ld;
        ab_en = drv;
        host_reset = 1;
        repeat (n) @(posedge clock);
        #1;
        chk("pins float", 0, {dlo_oe, dhi_oe, alo_oe});
        host_reset = 0;
        repeat (2) @(posedge clock);
        #1;
    endtask : hreset

    task automatic access(input logic wr, pr, bw, cm, input logic [15:0] a, d, output logic [15:0] q);
        int n;
        acc_req = 1;
        acc_write = wr;
        acc_prom = pr;
        byte_wide = bw;
        compat_mode = cm;
        acc_addr = a;
        acc_wdata = d;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin @(posedge clock); #1; n++; end
        chk("ready", 1, ready);
        @(posedge clock);
        #1;
        acc_req = 0;
        chk("addr pins", exp_pins(a, bw, cm), {ahi, alo_o});
        chk("strobes", {wr, !wr}, {rd_n, wr_n});
        chk("selects", pr ? 3'b011 : {2'b10, bw}, {bp_n, rl_n, rh_n});
        chk("data oe", wr ? (bw ? 16'h00FF : 16'hFFFF) : 16'h0000, {dhi_oe, dlo_oe});
        n = 0;
        while (done !== 1'b1 && n < 20) begin @(posedge clock); #1; n++; end
        chk("done delay", mbsl_pkg::MEM_STROBE_CYC, n);
        q = rdata;
        @(posedge clock);
        #1;
    endtask : access

    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        summarize();
    end

    initial begin
        logic [15:0] a, d, q, w;
        int n;
        void'($urandom(32'hF3DAE062));
        repeat (12) @(posedge clock);
        #1;
        rst = 0;
        @(posedge clock);
        #1;
        hreset(30, 1, 1);
        chk("cfg_a", sa, ca);
        chk("cfg_b", sb, cb);
        chk("cfg_c", sc, cc);
        chk("wide_slot", ws_s, wslot);
        chk("load start", 3'b111, {busy, nsel, dlo_oe == mbsl_pkg::NVM_PIN_OE});
        ab_en = 0;
        n = 0;
        while (ready !== 1'b1 && n < 50000) begin @(posedge clock); #1; n++; end
        chk("load end", 3'b001, {busy, nsel, ready});
        w = nvm_word(0);
        chk("cfg_a load", w[7:0], ca);
        chk("cfg_b load", w[15:8], cb);
        w = nvm_word(1);
        chk("cfg_c load", w[7:0], cc);
        for (int i = 0; i < 8; i++) begin
            // storage slots wrap on the low word bits: words 4,5 land first, then 2,3
            w = nvm_word((i / 2 + 2) % 4 + 2);
            prom_idx = 3'(i);
            #1;
            chk("prom_byte", (i % 2) ? w[15:8] : w[7:0], pbyte);
        end
        @(posedge clock);
        #1;
        for (int i = 0; i < 8; i++) begin
            a = 16'($urandom) & 16'hFFFE;
            d = 16'($urandom);
            access(1, 0, 0, 0, a, d, q);
            shadow[a] = d;
        end
        foreach (shadow[k]) begin
            access(0, 0, 0, 0, 16'(k), 16'h0000, q);
            chk("word read", shadow[k], q);
        end
        for (int cm = 0; cm < 2; cm++) begin
            a = 16'($urandom) | 16'h0001;
            d = 16'($urandom);
            access(1, 0, 1, 1'(cm), a, d, q);
            access(0, 0, 1, 1'(cm), a, 16'h0000, q);
            chk("byte read", d[7:0], q[7:0]);
        end
        for (int i = 0; i < 2; i++) begin
            a = 16'($urandom);
            access(0, 1, 0, 0, a, 16'h0000, q);
            chk("prom read", a[8:1] ^ 8'h5A, q[7:0]);
        end
        hreset(5, 1, 1);
        w = nvm_word(0);
        chk("short pulse cfg", w, {cb, ca});
        chk("short pulse busy", 0, busy);
        ab_en = 0;
        hreset(30, 0, 0);
        chk("undriven straps", 16'h0000, {cb, ca});
        chk("cfg_c no load", sc, cc);
        chk("no load busy", 0, busy);
        access(1, 0, 0, 0, 16'h1234, 16'hBEEF, q);
        access(0, 0, 0, 0, 16'h1234, 16'h0000, q);
        chk("read after reset", 16'hBEEF, q);
        summarize();
    end
endmodule : memory_bus_strap_loader_tb
